// ===== hw/mff_pkg.sv
// constants, mode type and adder decode shared by the multiply-accumulate filter files
package mff_pkg;

  // tap count and datapath widths
  localparam int NUM_TAPS  = 16;
  localparam int HALF_TAPS = NUM_TAPS / 2;
  localparam int TAP_W     = 4;
  localparam int CNT_W     = 5;
  localparam int DATA_W    = 17;
  localparam int COEF_W    = 18;
  localparam int PRE_W     = DATA_W + 1;
  localparam int PROD_W    = PRE_W + COEF_W;
  localparam int ACC_W     = 48;
  localparam int OUT_W     = 18;
  localparam int TRUNC_W   = 17;

  // sweep terminal indices (before any extra cycle)
  localparam logic [CNT_W-1:0] LAST_FULL = 5'h0F;
  localparam logic [CNT_W-1:0] LAST_HALF = 5'h07;
  localparam logic [TAP_W-1:0] HALF_OFS  = 4'h8;
  localparam logic [TAP_W-1:0] TAP_MAX   = 4'hF;

  // clocks from tap address to the accumulate edge
  localparam int MAC_LAT = 4;

  // rounding constant 0.0111... at the truncation point
  localparam logic [ACC_W-1:0] ROUND_C = 48'h0000_0000_FFFF;

  // adder_operation_select codes: Z in [6:4], Y in [3:2], X in [1:0]
  localparam logic [6:0] OP_MAC_ACC    = 7'h25;
  localparam logic [6:0] OP_LOAD_ROUND = 7'h35;
  localparam logic [6:0] OP_ROUND_CYC  = 7'h2C;
  localparam logic [6:0] OP_MERGE      = 7'h1E;
  localparam logic [6:0] OP_HOLD       = 7'h20;

  // field encodings of the operation select
  localparam logic [1:0] X_M    = 2'h1;
  localparam logic [1:0] X_P    = 2'h2;
  localparam logic [1:0] Y_C    = 2'h3;
  localparam logic [2:0] Z_PCIN = 3'h1;
  localparam logic [2:0] Z_P    = 3'h2;
  localparam logic [2:0] Z_C    = 3'h3;

  typedef enum logic [1:0] {MFF_SINGLE, MFF_SYMM, MFF_DUAL} mff_mode_e;

  // post-adder: load forces the feedback term to zero
  function automatic logic [ACC_W-1:0] mff_adder(input logic [6:0] op, input logic [ACC_W-1:0] p,
                                                 input logic [ACC_W-1:0] m, input logic [ACC_W-1:0] c,
                                                 input logic [ACC_W-1:0] pcin, input logic cin,
                                                 input logic load);
    logic [ACC_W-1:0] xy;
    logic [ACC_W-1:0] z;
    xy = '0;
    z  = '0;
    if (op[1:0] == X_M) xy = m;
    else if (op[1:0] == X_P) xy = p;
    if (op[3:2] == Y_C) xy = xy + c;
    if (op[6:4] == Z_PCIN) z = pcin;
    else if (op[6:4] == Z_P) z = load ? '0 : p;
    else if (op[6:4] == Z_C) z = c;
    return xy + z + {{(ACC_W-1){1'b0}}, cin};
  endfunction : mff_adder

endpackage : mff_pkg

// ===== hw/mff_coef_mem.sv
// small distributed coefficient memory with one write port and two registered read ports
`timescale 1ns/1ns
module mff_coef_mem
  import mff_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // write port
  input  wire logic                wrEn,
  input  wire logic [TAP_W-1:0]    wrAddr,
  input  wire logic [COEF_W-1:0]   wrData,
  // read ports
  input  wire logic [TAP_W-1:0]    rdAddrA,
  input  wire logic [TAP_W-1:0]    rdAddrB,
  output logic      [COEF_W-1:0]   rdDataA,
  output logic      [COEF_W-1:0]   rdDataB
);

  typedef struct packed {
    logic [NUM_TAPS-1:0][COEF_W-1:0] mem;
    logic [COEF_W-1:0]               rdA;
    logic [COEF_W-1:0]               rdB;
  } mff_coef_s;

  mff_coef_s s;
  mff_coef_s next_s;

  // registered reads return the old word on a same-address write
  always_comb begin
    next_s     = s;
    next_s.rdA = s.mem[rdAddrA];
    next_s.rdB = s.mem[rdAddrB];
    if (wrEn) next_s.mem[wrAddr] = wrData;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else s <= next_s;
  end

  assign rdDataA = s.rdA;
  assign rdDataB = s.rdB;

  property p_coef_read;
    @(posedge core_clk) disable iff (!rst_n)
      (wrEn ##1 (rdAddrA == $past(wrAddr))) |=> (rdDataA == $past(wrData, 2));
  endproperty
  a_coef_read: assert property (p_coef_read) else $error("coefficient read data wrong"); // R4

endmodule : mff_coef_mem

// ===== hw/mff_shift_buf.sv
// addressable shift buffer holding the sample history, newest at address zero
`timescale 1ns/1ns
module mff_shift_buf
  import mff_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // shift-in port
  input  wire logic                shiftEn,
  input  wire logic [DATA_W-1:0]   shiftData,
  // read ports
  input  wire logic [TAP_W-1:0]    rdAddrA,
  input  wire logic [TAP_W-1:0]    rdAddrB,
  output logic      [DATA_W-1:0]   rdDataA,
  output logic      [DATA_W-1:0]   rdDataB
);

  typedef struct packed {
    logic [NUM_TAPS-1:0][DATA_W-1:0] sr;
    logic [DATA_W-1:0]               rdA;
    logic [DATA_W-1:0]               rdB;
  } mff_sbuf_s;

  mff_sbuf_s s;
  mff_sbuf_s next_s;

  // reads take the pre-shift contents so the oldest sample leaves before the newest lands
  always_comb begin
    next_s     = s;
    next_s.rdA = s.sr[rdAddrA]; // R18
    next_s.rdB = s.sr[rdAddrB];
    if (shiftEn) next_s.sr = {s.sr[NUM_TAPS-2:0], shiftData}; // R4
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else s <= next_s;
  end

  assign rdDataA = s.rdA;
  assign rdDataB = s.rdB;

  property p_read_before_shift;
    @(posedge core_clk) disable iff (!rst_n)
      (shiftEn && rdAddrB == TAP_MAX) |=> (rdDataB == $past(s.sr[NUM_TAPS-1]) && s.sr[0] == $past(shiftData));
  endproperty
  a_read_before_shift: assert property (p_read_before_shift) else $error("oldest sample lost on shift"); // R18

endmodule : mff_shift_buf

// ===== hw/mff_filter.sv
// multiply-accumulate FIR filter: single, symmetric and dual-engine variants with rounding
// What this block does
// R1: no-extra-cycle rounding loads product plus constant
// R2: carry-in only on last accumulation cycle
// R3: rounding sign taken from penultimate sum
// R4: small filter uses shift buffer, small RAM
// R5: one tap counter addresses both memories
// R6: terminal count shifts in new sample
// R7: delayed terminal count captures, forces load
// R8: symmetric pre-adds mirrored samples before multiply
// R9: symmetric samples narrower than eighteen bits
// R10: fabric pre-adder is the clock-limiting path
// R11: symmetric needs two sample reads, coefficient read
// R12: mirrored reads run ascending and descending
// R13: dual splits taps over two engines
// R14: dual extra cycle merges and rounds
// R15: round adds 0.0111 plus carry if positive
// R16: separate round cycle uses opcode 0101100
// R17: load control delayed four clocks
// R18: oldest sample read before newest written
// R19: one-clock valid pulse per captured result
`timescale 1ns/1ns
module mff_filter
  import mff_pkg::*;
(
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  // configuration, taken at each sweep boundary
  input  wire mff_pkg::mff_mode_e          filterMode,
  input  wire logic                        roundNoExtra,
  // coefficient load
  input  wire logic                        coefWrEn,
  input  wire logic [mff_pkg::TAP_W-1:0]   coefWrAddr,
  input  wire logic [mff_pkg::COEF_W-1:0]  coefWrData,
  // sample source
  input  wire logic [mff_pkg::DATA_W-1:0]  sampleIn,
  output logic                             sampleTaken,
  // result consumer
  output logic      [mff_pkg::OUT_W-1:0]   result,
  output logic                             resultValid
);
  import mff_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]              cnt;
    mff_mode_e                     mode;
    logic                          noExtra;
    logic [MAC_LAT-1:0]            dFirst;
    logic [MAC_LAT-1:0]            dLast;
    logic [MAC_LAT-1:0]            dExtra;
    logic [MAC_LAT-1:0]            dFinal;
    logic [1:0][PRE_W-1:0]         opX;
    logic [1:0][COEF_W-1:0]        opC;
    logic [1:0][PROD_W-1:0]        prod;
    logic [1:0][ACC_W-1:0]         acc;
    logic [OUT_W-1:0]              result;
    logic                          resultValid;
    logic                          sampleTaken;
  } mff_filt_s;

  mff_filt_s s;
  mff_filt_s next_s;

  // second read address: mirrored tap when symmetric, upper half when dual
  function automatic logic [TAP_W-1:0] tapAddrB(input mff_mode_e mode, input logic [TAP_W-1:0] a);
    logic [TAP_W-1:0] b;
    b = a;
    if (mode == MFF_SYMM) b = TAP_MAX - a;
    else if (mode == MFF_DUAL) b = a + HALF_OFS;
    return b;
  endfunction : tapAddrB

  logic [TAP_W-1:0]  addrA;
  logic [TAP_W-1:0]  addrB;
  logic [TAP_W-1:0]  coefAddrB;
  logic [DATA_W-1:0] sampA;
  logic [DATA_W-1:0] sampB;
  logic [COEF_W-1:0] coefA;
  logic [COEF_W-1:0] coefB;
  logic [CNT_W-1:0]  lastIdx;
  logic [CNT_W-1:0]  tcIdx;
  logic              hasExtra;
  logic              tc;
  logic              isDual;
  logic              rndInLoad;
  logic              stgFirst;
  logic              stgLast;
  logic              stgExtra;
  logic [ACC_W-1:0]  mergeSum;
  logic [PRE_W-1:0]  preSum;

  // one counter addresses the sample buffer and the coefficient memory alike
  assign addrA     = s.cnt[TAP_W-1:0]; // R5
  assign addrB     = tapAddrB(s.mode, addrA); // R12
  // symmetric pairs share coefficient A, so B only matters for the dual split
  assign coefAddrB = tapAddrB(s.mode, addrA); // R13

  // sweep length: half the taps in symmetric and dual modes, all taps in single, plus any extra cycle
  assign isDual    = (s.mode == MFF_DUAL);
  assign hasExtra  = isDual || !s.noExtra;
  assign lastIdx   = (s.mode == MFF_SINGLE) ? LAST_FULL : LAST_HALF; // R8
  assign tcIdx     = lastIdx + CNT_W'(hasExtra);
  assign tc        = (s.cnt == tcIdx);
  assign rndInLoad = s.noExtra && !isDual;

  // stage flags that line up with the product reaching the accumulator
  assign stgFirst  = s.dFirst[MAC_LAT-2]; // R17
  assign stgLast   = s.dLast[MAC_LAT-2];
  assign stgExtra  = s.dExtra[MAC_LAT-2];
  assign mergeSum  = s.acc[0] + s.acc[1];

  // the fabric pre-adder sets the clock ceiling; it is registered straight after
  assign preSum = {sampA[DATA_W-1], sampA} + {sampB[DATA_W-1], sampB}; // R10

  mff_shift_buf u_sbuf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .shiftEn   (tc),
    .shiftData (sampleIn),
    .rdAddrA   (addrA),
    .rdAddrB   (addrB),
    .rdDataA   (sampA),
    .rdDataB   (sampB)
  ); // R4 R11

  mff_coef_mem u_coef (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wrEn     (coefWrEn),
    .wrAddr   (coefWrAddr),
    .wrData   (coefWrData),
    .rdAddrA  (addrA),
    .rdAddrB  (coefAddrB),
    .rdDataA  (coefA),
    .rdDataB  (coefB)
  ); // R4 R11

  wire [PROD_W-1:0] prodNext [2];
  wire [ACC_W-1:0]  sumNext  [2];

  // two multiply_accumulate engines; engine 1 only contributes in dual mode
  for (genvar e = 0; e < 2; e++) begin : eng
    logic [6:0]       op;
    logic             cin;
    logic             load;
    logic [ACC_W-1:0] prodExt;

    assign prodNext[e] = PROD_W'($signed(s.opX[e]) * $signed(s.opC[e]));
    assign prodExt     = {{(ACC_W-PROD_W){s.prod[e][PROD_W-1]}}, s.prod[e]};

    // operation select per stage; carry adds the half lsb for positive values
    always_comb begin
      op   = OP_MAC_ACC;
      cin  = 1'b0;
      load = 1'b0;
      if (stgFirst) begin
        load = 1'b1; // R7
        if (rndInLoad) op = OP_LOAD_ROUND; // R1
      end
      if (stgLast && rndInLoad) cin = ~s.acc[e][ACC_W-1]; // R2 R3
      if (stgExtra) begin
        if (isDual) begin
          if (e == 1) begin
            op  = OP_MERGE; // R14
            cin = ~mergeSum[ACC_W-1];
          end else begin
            op  = OP_HOLD;
          end
        end else begin
          op  = OP_ROUND_CYC; // R16
          cin = ~s.acc[e][ACC_W-1]; // R15
        end
      end
    end

    assign sumNext[e] = mff_adder(op, s.acc[e], prodExt, ROUND_C, s.acc[0], cin, load);
  end

  // next-state: counter, control delay line, operand, product and accumulator stages
  always_comb begin
    next_s     = s;
    next_s.cnt = tc ? '0 : CNT_W'(s.cnt + 1'b1);
    // mode switches only at a sweep boundary; the result in flight may be mixed
    if (tc) begin
      next_s.mode    = filterMode;
      next_s.noExtra = roundNoExtra;
    end
    next_s.dFirst = {s.dFirst[MAC_LAT-2:0], s.cnt == '0};
    next_s.dLast  = {s.dLast[MAC_LAT-2:0], s.cnt == lastIdx};
    next_s.dExtra = {s.dExtra[MAC_LAT-2:0], tc && hasExtra};
    next_s.dFinal = {s.dFinal[MAC_LAT-2:0], tc}; // R7
    // operands: one extra bit of headroom carries the pre-adder growth
    next_s.opX[0] = (s.mode == MFF_SYMM) ? preSum : {sampA[DATA_W-1], sampA}; // R8 R9
    next_s.opX[1] = {sampB[DATA_W-1], sampB};
    next_s.opC[0] = coefA;
    next_s.opC[1] = coefB;
    for (int e = 0; e < 2; e++) begin
      next_s.prod[e] = prodNext[e];
      next_s.acc[e]  = sumNext[e];
    end
    next_s.sampleTaken = tc; // R6
    next_s.resultValid = s.dFinal[MAC_LAT-1]; // R19
    if (s.dFinal[MAC_LAT-1]) begin
      next_s.result = isDual ? s.acc[1][TRUNC_W +: OUT_W] : s.acc[0][TRUNC_W +: OUT_W]; // R7
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else s <= next_s;
  end

  // outputs come straight from state flops
  assign sampleTaken = s.sampleTaken;
  assign result      = s.result;
  assign resultValid = s.resultValid;

  // helper for the symmetric product check
  logic [PROD_W-1:0] symProd;
  assign symProd = PROD_W'($signed(preSum) * $signed(coefA));

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_round_load;
    (stgFirst && rndInLoad) |=> (s.acc[0] == $past(ROUND_C) + $past(eng[0].prodExt));
  endproperty
  a_round_load: assert property (p_round_load) else $error("first product not loaded with round constant"); // R1

  property p_cin_last;
    eng[0].cin |-> ((stgLast && rndInLoad) || stgExtra);
  endproperty
  a_cin_last: assert property (p_cin_last) else $error("carry-in outside last or round cycle"); // R2

  property p_cin_sign;
    (stgLast && rndInLoad) |-> (eng[0].cin == !s.acc[0][ACC_W-1]);
  endproperty
  a_cin_sign: assert property (p_cin_sign) else $error("carry-in not from penultimate sign"); // R3

  property p_sweep_gap;
    sampleTaken |=> (!sampleTaken) [*7];
  endproperty
  a_sweep_gap: assert property (p_sweep_gap) else $error("samples taken closer than one sweep"); // R6

  property p_capture_delay;
    (sampleTaken && s.dFinal[0]) |-> ##4 resultValid;
  endproperty
  a_capture_delay: assert property (p_capture_delay) else $error("capture not four clocks after count end"); // R17

  property p_valid_pulse;
    resultValid |=> !resultValid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result valid longer than one clock"); // R19

  property p_mirror_addr;
    (s.mode == MFF_SYMM && s.cnt <= LAST_HALF) |-> (TAP_W'(addrA + addrB) == TAP_MAX);
  endproperty
  a_mirror_addr: assert property (p_mirror_addr) else $error("mirrored reads not paired"); // R12

  property p_symm_prod;
    (s.mode == MFF_SYMM) ##1 (s.mode == MFF_SYMM) |=> (s.prod[0] == $past(symProd, 2));
  endproperty
  a_symm_prod: assert property (p_symm_prod) else $error("symmetric product not of pre-added pair"); // R8

  property p_merge;
    (stgExtra && isDual) |=> (s.acc[1] == $past(mergeSum) + ROUND_C + ACC_W'($past(eng[1].cin)));
  endproperty
  a_merge: assert property (p_merge) else $error("dual partial sums not merged and rounded"); // R14

  property p_round_cycle;
    (stgExtra && !isDual) |=> (s.acc[0] == $past(s.acc[0]) + ROUND_C + ACC_W'(!$past(s.acc[0][ACC_W-1])));
  endproperty
  a_round_cycle: assert property (p_round_cycle) else $error("extra round cycle sum wrong"); // R15

  // plain load must drop the old sum, otherwise results leak into the next sweep
  property p_load_plain;
    (stgFirst && !rndInLoad) |=> (s.acc[0] == $past(eng[0].prodExt));
  endproperty
  a_load_plain: assert property (p_load_plain) else $error("first product not loaded over old sum"); // R7

  property p_sample_take;
    tc |=> sampleTaken;
  endproperty
  a_sample_take: assert property (p_sample_take) else $error("terminal count did not take a sample"); // R6

  property p_mirror_order;
    (s.mode == MFF_SYMM && s.cnt < LAST_HALF) |=>
      (addrA == TAP_W'($past(addrA) + 1'b1) && addrB == TAP_W'($past(addrB) - 1'b1));
  endproperty
  a_mirror_order: assert property (p_mirror_order) else $error("mirrored reads not ascending and descending"); // R12

  property p_dual_hold;
    (stgExtra && isDual) |=> (s.acc[0] == $past(s.acc[0]));
  endproperty
  a_dual_hold: assert property (p_dual_hold) else $error("engine zero sum disturbed during merge"); // R14

  property p_cnt_range;
    s.cnt <= tcIdx;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("tap counter beyond sweep end"); // R5

  c_single: cover property (resultValid && s.mode == MFF_SINGLE && !s.noExtra);
  c_symm:   cover property (resultValid && s.mode == MFF_SYMM && s.noExtra);
  c_dual:   cover property (resultValid && s.mode == MFF_DUAL);
  c_single_fold: cover property (resultValid && s.mode == MFF_SINGLE && s.noExtra);
  c_symm_extra:  cover property (resultValid && s.mode == MFF_SYMM && !s.noExtra);

endmodule : mff_filter

// ===== dv/mff_stream_partner.sv
// upstream sample source and downstream result consumer facing the filter
`timescale 1ns/1ns
module mff_stream_partner
  import mff_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // sample link
  input  wire logic                       sampleTaken,
  output logic      [mff_pkg::DATA_W-1:0] sampleIn,
  // result link
  input  wire logic [mff_pkg::OUT_W-1:0]  result,
  input  wire logic                       resultValid,
  output logic      [mff_pkg::OUT_W-1:0]  lastResult,
  output int                              resultCount
);
  int   idx;
  logic tk;

  // extremes every few samples stress the pre-adder width
  function automatic logic [DATA_W-1:0] sample_of(input int i);
    if (i % 5 == 0) return 17'h10000;
    if (i % 5 == 1) return 17'h0FFFF;
    return DATA_W'(i * 12345);
  endfunction : sample_of

  initial begin
    idx = 0;
    sampleIn = sample_of(0);
    lastResult = '0;
    resultCount = 0;
  end

  // one new sample per sweep, changed just after the edge that reports the take
  always @(posedge core_clk) begin
    tk = sampleTaken;
    if (resultValid) begin
      lastResult = result;  // no back-pressure, so take it in the valid cycle
      resultCount++;
    end
    #1;
    if (!rst_n) idx = 0;
    else if (tk) idx++;
    sampleIn = sample_of(idx);
  end
endmodule : mff_stream_partner

// ===== dv/tb.sv
// self-checking bench for the multiply-accumulate filter variants
`timescale 1ns/1ns
module tb;
  import mff_pkg::*;
  logic                     core_clk;
  logic                     rst_n;
  mff_mode_e                filterMode;
  logic                     roundNoExtra;
  logic                     coefWrEn;
  logic [TAP_W-1:0]         coefWrAddr;
  logic [COEF_W-1:0]        coefWrData;
  logic [DATA_W-1:0]        sampleIn;
  logic                     sampleTaken;
  logic [OUT_W-1:0]         result;
  logic                     resultValid;
  logic [OUT_W-1:0]         lastResult;
  int                       resultCount;
  int                       n_errors;
  int                       tests_run;
  int                       skipN;
  int                       sinceTake;
  mff_mode_e                cfgMode;
  logic                     cfgNe;
  logic                     skipNow;
  logic signed [COEF_W-1:0] h [16];
  logic signed [DATA_W-1:0] x [16];
  logic [OUT_W-1:0]         expQ [$];
  logic                     skipQ [$];

  mff_filter u_dut (.core_clk(core_clk), .rst_n(rst_n), .filterMode(filterMode), .roundNoExtra(roundNoExtra),
    .coefWrEn(coefWrEn), .coefWrAddr(coefWrAddr), .coefWrData(coefWrData), .sampleIn(sampleIn),
    .sampleTaken(sampleTaken), .result(result), .resultValid(resultValid));
  mff_stream_partner u_src (.core_clk(core_clk), .rst_n(rst_n), .sampleTaken(sampleTaken), .sampleIn(sampleIn),
    .result(result), .resultValid(resultValid), .lastResult(lastResult), .resultCount(resultCount));

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // symmetric rounding; no-extra-cycle mode takes its sign from the sum before the last product, constant included
  function automatic logic [OUT_W-1:0] ref_result(input mff_mode_e m, input logic ne);
    longint s;
    longint last;
    longint sg;
    logic [47:0] r;
    s = 0;
    for (int k = 0; k < 16; k++) begin
      if (m != MFF_SYMM) s += longint'(h[k]) * longint'(x[k]);
      else if (k < 8) s += longint'(h[k]) * (longint'(x[k]) + longint'(x[15-k]));
    end
    last = (m == MFF_SYMM) ? longint'(h[7]) * (longint'(x[7]) + longint'(x[8])) : longint'(h[15]) * longint'(x[15]);
    sg = (ne && m != MFF_DUAL) ? s - last + longint'(ROUND_C) : s;
    r = 48'(s) + ROUND_C + ((sg >= 0) ? 48'h1 : 48'h0);
    return r[34:17];
  endfunction : ref_result

  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end

  // reference delay line and result timing, judged at every edge
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cfgMode = MFF_SINGLE;
      cfgNe = 0;
      sinceTake = 0;
      expQ.delete();
      skipQ.delete();
      foreach (x[k]) x[k] = '0;
    end else begin
      sinceTake++;
      if (sampleTaken) begin
        skipNow = (skipN > 0);
        if (!skipNow) check("sweep length", 48'(sinceTake), (cfgMode == MFF_DUAL) ? 48'h9 : ((cfgMode == MFF_SYMM) ? 48'h8 : 48'h10) + (cfgNe ? 48'h0 : 48'h1));
        expQ.push_back(ref_result(cfgMode, cfgNe));
        skipQ.push_back(skipNow);
        for (int k = 15; k > 0; k--) x[k] = x[k-1];
        x[0] = sampleIn;
        cfgMode = filterMode;
        cfgNe = roundNoExtra;
        if (skipN > 0) skipN--;
        sinceTake = 0;
      end
      if (resultValid) begin
        if (expQ.size() == 0) check("result queue", 48'h0, 48'h1);
        else begin
          skipNow = skipQ.pop_front();
          if (!skipNow) check("result", 48'(result), 48'(expQ.pop_front()));
          else void'(expQ.pop_front());
          if (!skipNow) check("valid delay", 48'(sinceTake), 48'h4);
        end
      end
    end
  end

  task automatic wait_results(input int n);
    int target;
    target = resultCount + n;
    for (int c = 0; c < 40 * n + 200 && resultCount < target; c++) @(posedge core_clk);
    #1;
    if (resultCount < target) begin
      check("result count", 48'(resultCount), 48'(target));
      complete_run();
    end
  endtask : wait_results

  // config is changed only just after a take edge so the bench knows when it lands
  task automatic set_cfg(input mff_mode_e m, input logic ne);
    int c;
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (sampleTaken !== 1'b1 && c < 40);
    #1;
    if (c >= 40) begin
      check("take seen", 48'h0, 48'h1);
      complete_run();
    end
    filterMode = m;
    roundNoExtra = ne;
    skipN = 3;
  endtask : set_cfg

  // back-to-back coefficient writes; symmetric sets mirror tap k onto 15-k
  task automatic load_coefs(input logic symm);
    int j;
    // sweeps running during the load mix old and new coefficients
    skipN = 4;
    for (int k = 0; k < 16; k++) begin
      j = (symm && k > 7) ? 15 - k : k;
      h[k] = (j == 0) ? 18'h1FFFF : (j == 3) ? 18'h20000 : COEF_W'(j * 2311 - 9000);
      coefWrEn = 1;
      coefWrAddr = TAP_W'(k);
      coefWrData = h[k];
      @(posedge core_clk);
      #1;
    end
    coefWrEn = 0;
    skipN = 4;
  endtask : load_coefs

  task automatic sc_single_extra();
    load_coefs(0);
    set_cfg(MFF_SINGLE, 0);
    wait_results(8);
  endtask : sc_single_extra

  task automatic sc_single_noextra();
    set_cfg(MFF_SINGLE, 1);
    wait_results(8);
  endtask : sc_single_noextra

  task automatic sc_symm();
    load_coefs(1);
    set_cfg(MFF_SYMM, 0);
    wait_results(8);
    set_cfg(MFF_SYMM, 1);
    wait_results(8);
  endtask : sc_symm

  task automatic sc_dual();
    load_coefs(0);
    set_cfg(MFF_DUAL, 1);
    wait_results(8);
  endtask : sc_dual

  initial begin
    rst_n = 0;
    filterMode = MFF_SINGLE;
    roundNoExtra = 0;
    coefWrEn = 0;
    coefWrAddr = '0;
    coefWrData = '0;
    n_errors = 0;
    tests_run = 0;
    skipN = 2;
    foreach (h[k]) h[k] = '0;
    repeat (12) @(posedge core_clk);
    #1;
    rst_n = 1;
    wait_results(3);
    sc_single_extra();
    sc_single_noextra();
    sc_symm();
    sc_dual();
    complete_run();
  end
endmodule : tb
